// [rtl/qdc_event_readout_regs.sv]
// Event word formatter, event buffer and basic control registers.
//
// Notes on behaviour
// RQ1: Header: slot, type 010, crate, count.
// RQ2: Data word: type 000, channel number field.
// RQ3: Bit 13 flags value below threshold.
// RQ4: Bit 12 overflow; bits 11..0 value.
// RQ5: Trailer type 100 with 24-bit event count.
// RQ6: Not-valid type 110 lacks slot field.
// RQ7: Empty buffer read returns not-valid word.
// RQ8: Channels stored interleaved by halves.
// RQ9: Suppressed channels omitted, order kept.
// RQ10: Empty events not stored under suppression.
// RQ11: Read-only 16-bit firmware revision.
// RQ12: Slot register loads from slot lines on reset.
// RQ13: Without slot lines, writable, default ones.
// RQ14: With slot lines, slot writes unacknowledged.
// RQ15: Master resets after slot write to apply.
// RQ16: Chain address register resets to 0xAA.
// RQ17: Set register sets bits written one.
// RQ18: Clear register clears bits written one.
// RQ19: Bus error flag cleared by both resets.
// RQ20: Address source: switch or decoder registers.
// RQ21: Software reset holds until cleared.
// RQ22: Interrupt level three bits, status byte.
`include "qdc_readout_params.svh"
`timescale 1ns/100ps
`default_nettype none
module qdc_event_readout_regs #(
	parameter int NCH = 32,
	parameter int DEPTH = 128,
	parameter logic [15:0] FW_REV = 16'h0000, // Arbitrary value.
	parameter bit HAS_SLOT_LINES = 1'b1
)(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Register port, 16-bit offset within the module.
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_ack,
	// Backplane and configuration inputs.
	input wire logic [4:0] i_slot_number,
	input wire logic [7:0] i_crate,
	input wire logic [7:0] i_switch_base,
	input wire logic [7:0] i_address_decoder_reg,
	input wire logic i_bus_error_event,
	input wire logic i_zero_suppress,
	input wire logic i_keep_below,
	input wire logic [23:0] i_event_count,
	// Converted event input, all channels at once.
	input wire logic i_conv_valid,
	input wire logic [NCH*12-1:0] i_conv_value,
	input wire logic [NCH-1:0] i_conv_over,
	input wire logic [NCH-1:0] i_conv_below,
	input wire logic [NCH-1:0] i_chan_enable,
	// Status outputs.
	output logic o_conv_ready,
	output logic [7:0] o_base_addr,
	output logic o_module_reset,
	output logic [2:0] o_irq_level,
	output logic o_irq_enable,
	output logic [7:0] o_irq_status_id,
	output logic o_buf_empty
);
	import qdc_readout_pkg::*;

	localparam int HALF = NCH / 2;
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(NCH);

	// Refuse channel counts and depths that the builder cannot serve.
	if (NCH != 32 && NCH != 16)
	begin : g_bad_nch
		$error("NCH must be 16 or 32");
	end
	if (DEPTH < NCH + 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("DEPTH must be a power of two above NCH+2");
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers.
	logic [4:0] slot_r;
	logic [7:0] chain_r;
	reg16_t set1_r;
	logic [2:0] irq_lvl_r;
	logic [7:0] irq_vec_r;
	logic sw_reset;
	logic slot_load_r;
	logic wr_slot, wr_chain, wr_set1, wr_clr1, wr_lvl, wr_vec;

	assign wr_slot = i_reg_wr && i_reg_addr == `OFS_SLOT;
	assign wr_chain = i_reg_wr && i_reg_addr == `OFS_CHAIN;
	assign wr_set1 = i_reg_wr && i_reg_addr == `OFS_SET1;
	assign wr_clr1 = i_reg_wr && i_reg_addr == `OFS_CLR1;
	assign wr_lvl = i_reg_wr && i_reg_addr == `OFS_IRQ_LVL;
	assign wr_vec = i_reg_wr && i_reg_addr == `OFS_IRQ_VEC;
	assign sw_reset = set1_r[`BIT_SW_RESET];

	// The slot value is captured on the first edge after a hardware reset, and from one edge late on every edge while a software reset is held.
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			slot_load_r <= 1'b1;
		else
			slot_load_r <= sw_reset;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			slot_r <= `SLOT_DEFAULT;
		// RQ12: capture slot lines
		else if (slot_load_r && HAS_SLOT_LINES)
			slot_r <= i_slot_number;
		// RQ13: writable without lines
		else if (wr_slot && !HAS_SLOT_LINES)
			slot_r <= i_reg_wdata[4:0];
	end

	// RQ16: chain address default
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			chain_r <= `CHAIN_RESET;
		else if (wr_chain)
			chain_r <= i_reg_wdata[7:0];
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			set1_r <= 16'h0000;
		else
		begin
			// RQ17: write one sets
			if (wr_set1)
				set1_r <= set1_r | (i_reg_wdata & `SET1_MASK);
			// RQ18: write one clears
			else if (wr_clr1)
				set1_r <= set1_r & ~(i_reg_wdata & `SET1_MASK);
			// RQ19: soft reset clears flag
			if (sw_reset && !wr_clr1)
				set1_r[`BIT_BUS_ERR] <= 1'b0;
			// RQ19: flag set wins clear
			if (i_bus_error_event)
				set1_r[`BIT_BUS_ERR] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			irq_lvl_r <= `IRQ_LVL_RESET;
			irq_vec_r <= `IRQ_VEC_RESET;
		end
		else
		begin
			if (wr_lvl)
				irq_lvl_r <= i_reg_wdata[2:0];
			if (wr_vec)
				irq_vec_r <= i_reg_wdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event builder and buffer.
	word_t mem [DEPTH];
	logic [AW:0] wr_ptr_r, rd_ptr_r, wr_cur_r;
	logic [NCH*12-1:0] val_r;
	logic [NCH-1:0] ovr_r, blw_r, keep_r;
	logic [CW-1:0] idx_r;
	logic [5:0] cnt_r;
	build_e st_r;
	logic [CW-1:0] chan;
	logic [NCH-1:0] keep;
	logic [AW:0] used;
	logic [11:0] cur_val;
	logic empty;
	logic take;

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_keep
			// RQ9: drop suppressed channels
			assign keep[g] = i_chan_enable[g] && !i_conv_over[g] &&
				(!i_conv_below[g] || i_keep_below);
		end
	endgenerate

	// RQ8: interleave halves
	assign chan = idx_r[0] ? CW'(HALF + int'(idx_r[CW-1:1])) :
		CW'(idx_r[CW-1:1]);
	assign cur_val = val_r[chan*12 +: 12];
	assign used = wr_cur_r - rd_ptr_r;
	assign empty = wr_ptr_r == rd_ptr_r;
	assign take = i_conv_valid && o_conv_ready &&
		(|keep || !i_zero_suppress);

	// Ready is registered and drops on the edge that takes an event.
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			o_conv_ready <= 1'b0;
		else
			o_conv_ready <= st_r == ST_IDLE && !take && !sw_reset &&
				used <= (AW+1)'(DEPTH - NCH - 2);
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_r <= ST_IDLE;
			val_r <= '0;
			ovr_r <= '0;
			blw_r <= '0;
			keep_r <= '0;
			idx_r <= '0;
			cnt_r <= 6'h00;
			wr_ptr_r <= '0;
			wr_cur_r <= '0;
		end
		else if (sw_reset)
		begin
			st_r <= ST_IDLE;
			wr_ptr_r <= '0;
			wr_cur_r <= '0;
		end
		else
		begin
			case (st_r)
				ST_IDLE:
				begin
					// RQ10: skip empty events
					if (take)
					begin
						val_r <= i_conv_value;
						ovr_r <= i_conv_over;
						blw_r <= i_conv_below;
						keep_r <= i_zero_suppress ? keep : i_chan_enable;
						cnt_r <= 6'($countones(i_zero_suppress ?
							keep : i_chan_enable));
						idx_r <= '0;
						wr_cur_r <= wr_ptr_r + 1'b1;
						st_r <= ST_HEADER;
					end
				end
				ST_HEADER:
					st_r <= ST_DATA;
				ST_DATA:
				begin
					if (keep_r[chan])
						wr_cur_r <= wr_cur_r + 1'b1;
					if (idx_r == CW'(NCH - 1))
						st_r <= ST_TRAILER;
					idx_r <= idx_r + 1'b1;
				end
				ST_TRAILER:
				begin
					// RQ10: commit stored event
					wr_ptr_r <= wr_cur_r + 1'b1;
					wr_cur_r <= wr_cur_r + 1'b1;
					st_r <= ST_IDLE;
				end
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		case (st_r)
			ST_HEADER:
				// RQ1: header word
				mem[wr_ptr_r[AW-1:0]] <= {slot_r, `TYPE_HEADER, i_crate,
					2'b00, cnt_r, 8'h00};
			ST_DATA:
				// RQ2: data word fields
				if (keep_r[chan])
					mem[wr_cur_r[AW-1:0]] <= {slot_r, `TYPE_DATUM,
						3'b000, (NCH == 16) ? {chan[3:0], 1'b0} : 5'(chan),
						2'b00,
						// RQ3: below threshold bit
						blw_r[chan],
						// RQ4: overflow and value
						ovr_r[chan], cur_val};
			ST_TRAILER:
				// RQ5: trailer with count
				mem[wr_cur_r[AW-1:0]] <= {slot_r, `TYPE_TRAILER,
					i_event_count};
			default:
				;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register read and acknowledge.
	logic rd_buf;
	assign rd_buf = i_reg_addr <= `OFS_BUF_TOP;

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			rd_ptr_r <= '0;
		else if (sw_reset)
			rd_ptr_r <= '0;
		else if (i_reg_rd && rd_buf && !empty)
			rd_ptr_r <= rd_ptr_r + 1'b1;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_reg_rdata <= 32'h0000_0000;
			o_reg_ack <= 1'b0;
		end
		else
		begin
			o_reg_ack <= 1'b0;
			o_reg_rdata <= 32'h0000_0000;
			if (i_reg_rd)
			begin
				o_reg_ack <= 1'b1;
				if (rd_buf)
					// RQ7: not-valid when empty
					// RQ6: not-valid lacks slot
					o_reg_rdata <= empty ? {5'h00, `TYPE_INVALID, 24'h00_0000}
						: mem[rd_ptr_r[AW-1:0]];
				else
					case (i_reg_addr)
						// RQ11: firmware revision
						`OFS_FW_REV: o_reg_rdata <= {16'h0000, FW_REV};
						`OFS_SLOT: o_reg_rdata <= {27'h000_0000, slot_r};
						`OFS_CHAIN: o_reg_rdata <= {24'h00_0000, chain_r};
						`OFS_SET1: o_reg_rdata <= {16'h0000, set1_r};
						`OFS_IRQ_LVL: o_reg_rdata <= {29'h0000_0000, irq_lvl_r};
						`OFS_IRQ_VEC: o_reg_rdata <= {24'h00_0000, irq_vec_r};
						default: o_reg_rdata <= 32'h0000_0000;
					endcase
			end
			// RQ14: no ack with slot lines
			else if (i_reg_wr)
				o_reg_ack <= !(wr_slot && HAS_SLOT_LINES);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs.
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_base_addr <= 8'h00;
			o_module_reset <= 1'b0;
			o_irq_level <= `IRQ_LVL_RESET;
			o_irq_enable <= 1'b0;
			o_irq_status_id <= `IRQ_VEC_RESET;
			o_buf_empty <= 1'b1;
		end
		else
		begin
			// RQ20: base address source
			o_base_addr <= set1_r[`BIT_SEL_ADDR] ? i_address_decoder_reg :
				i_switch_base;
			// RQ21: held software reset
			o_module_reset <= sw_reset;
			// RQ22: level zero disables
			o_irq_level <= irq_lvl_r;
			o_irq_enable <= irq_lvl_r != 3'h0;
			o_irq_status_id <= irq_vec_r;
			o_buf_empty <= empty;
		end
	end
endmodule
`default_nettype wire

// [rtl/qdc_readout_params.svh]
// Constants for the event readout register bank.
`ifndef QDC_READOUT_PARAMS_SVH
`define QDC_READOUT_PARAMS_SVH
`define OFS_FW_REV 16'h1000
`define OFS_SLOT 16'h1002
`define OFS_CHAIN 16'h1004
`define OFS_SET1 16'h1006
`define OFS_CLR1 16'h1008
`define OFS_IRQ_LVL 16'h100A
`define OFS_IRQ_VEC 16'h100C
`define OFS_BUF_TOP 16'h07FC
`define TYPE_HEADER 3'h0_2
`define TYPE_DATUM 3'h0_0
`define TYPE_TRAILER 3'h0_4
`define TYPE_INVALID 3'h0_6
`define CHAIN_RESET 8'h00AA
`define SLOT_DEFAULT 5'h1F
`define BIT_BUS_ERR 3
`define BIT_SEL_ADDR 4
`define BIT_SW_RESET 7
`define SET1_MASK 16'h0098
`define IRQ_LVL_RESET 3'h0
`define IRQ_VEC_RESET 8'h00
`define BELOW_BIT 13
`define OVER_BIT 12
`endif

// [rtl/qdc_readout_pkg.sv]
// Types shared by the event readout register bank.
package qdc_readout_pkg;
	typedef logic [31:0] word_t;
	typedef logic [15:0] reg16_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HEADER,
		ST_DATA,
		ST_TRAILER
	} build_e;
endpackage

// [testbench/qdc_readout_chk_properties.sv]
// Port-level properties of the event readout register bank.
`include "qdc_readout_params.svh"
`timescale 1ns/100ps
`default_nettype none
module qdc_readout_chk #(
	parameter logic [15:0] FW_REV = 16'h0000,
	parameter bit HAS_SLOT_LINES = 1'b1
)(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Watched ports of the bank.
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic [31:0] o_reg_rdata,
	input wire logic o_reg_ack,
	input wire logic o_module_reset,
	input wire logic [2:0] o_irq_level,
	input wire logic o_irq_enable,
	input wire logic o_buf_empty
);
default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (!i_nrst);
////////////////////////////////////////////////////////////////////////
chk_read_acked: assert property (
	i_reg_rd |=> o_reg_ack) else $error("read not acknowledged");
chk_ack_cause: assert property (
	$rose(o_reg_ack) |-> $past(i_reg_rd || i_reg_wr))
	else $error("ack without request");
chk_slot_no_ack: assert property (
	HAS_SLOT_LINES && i_reg_wr && !i_reg_rd && i_reg_addr == `OFS_SLOT
	|=> !o_reg_ack) else $error("slot write acknowledged");
chk_rdata_idle: assert property (
	!o_reg_ack |-> o_reg_rdata == 32'h0000_0000)
	else $error("read data outside ack");
chk_empty_word: assert property (
	i_reg_rd && i_reg_addr <= `OFS_BUF_TOP
	|=> o_buf_empty == (o_reg_rdata == 32'h0600_0000))
	else $error("empty read wrong");
chk_fw_value: assert property (
	i_reg_rd && i_reg_addr == `OFS_FW_REV
	|=> o_reg_rdata == {16'h0000, FW_REV}) else $error("revision wrong");
chk_hold_set: assert property (
	i_reg_wr && !i_reg_rd && i_reg_addr == `OFS_SET1 && i_reg_wdata[7]
	##1 !(i_reg_wr && i_reg_addr == `OFS_CLR1 && i_reg_wdata[7])
	|=> o_module_reset [*2]) else $error("hold reset not set");
chk_hold_clear: assert property (
	i_reg_wr && !i_reg_rd && i_reg_addr == `OFS_CLR1 && i_reg_wdata[7]
	|=> ##1 !o_module_reset) else $error("hold reset not cleared");
chk_irq_gate: assert property (
	o_irq_enable == (o_irq_level != 3'h0)) else $error("irq enable wrong");
endmodule
bind qdc_event_readout_regs qdc_readout_chk #(.FW_REV(FW_REV),
	.HAS_SLOT_LINES(HAS_SLOT_LINES)) qdc_readout_chk_i (
	.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_rd(i_reg_rd),
	.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
	.o_reg_ack(o_reg_ack), .o_module_reset(o_module_reset),
	.o_irq_level(o_irq_level), .o_irq_enable(o_irq_enable),
	.o_buf_empty(o_buf_empty));
`default_nettype wire

// [testbench/vme_master.sv]
// Bus master model issuing single register accesses.
`timescale 1ns/100ps
`default_nettype none
module vme_master (
	// Clock and answer.
	input wire logic i_clk_sys,
	input wire logic i_ack,
	input wire logic [31:0] i_rdata,
	// Request.
	output logic o_rd,
	output logic o_wr,
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata
);
initial
begin
	o_rd = 1'b0;
	o_wr = 1'b0;
	o_addr = 16'h0000;
	o_wdata = 16'h0000;
end
// The strobe is a one-cycle pulse; the answer is awaited a few cycles.
task automatic acc(input logic r, input logic [15:0] a,
	input logic [15:0] d, output logic [31:0] q, output logic ok);
	@(negedge i_clk_sys);
	o_rd = r;
	o_wr = !r;
	o_addr = a;
	o_wdata = d;
	@(negedge i_clk_sys);
	o_rd = 1'b0;
	o_wr = 1'b0;
	ok = (i_ack === 1'b1);
	for (int n = 0; n < 3 && !ok; n++)
	begin
		@(negedge i_clk_sys);
		ok = (i_ack === 1'b1);
	end
	q = i_rdata;
endtask
endmodule
`default_nettype wire

// [testbench/qdc_event_readout_regs_test.sv]
// Register and event word checks for the readout bank.
`include "qdc_readout_params.svh"
`timescale 1ns/100ps
`default_nettype none
module qdc_event_readout_regs_test;
import qdc_readout_pkg::*;
logic clk = 1'b0, nrst = 1'b0, rd, wr, ack, cv = 1'b0, rdy, be = 1'b0;
logic zs = 1'b0, kb = 1'b0, mrst, iren, empty;
logic [15:0] addr, wd, en = 16'h0000, ov = 16'h0000, bl = 16'h0000;
logic [31:0] rdata;
logic [191:0] val;
logic [7:0] base, sid;
logic [2:0] lvl;
logic [4:0] slot = 5'h0B;
int error_cnt = 0, checks = 0, cyc = 0;
always #5 clk = ~clk;
// The revision value is arbitrary.
qdc_event_readout_regs #(.NCH(16), .FW_REV(16'h0A5C))
	qdc_event_readout_regs_i (
	.i_clk_sys(clk), .i_nrst(nrst), .i_reg_rd(rd), .i_reg_wr(wr),
	.i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata),
	.o_reg_ack(ack), .i_slot_number(slot), .i_crate(8'h5A),
	.i_switch_base(8'h31), .i_address_decoder_reg(8'hC4),
	.i_bus_error_event(be), .i_zero_suppress(zs), .i_keep_below(kb),
	.i_event_count(24'h00_1234), .i_conv_valid(cv), .i_conv_value(val),
	.i_conv_over(ov), .i_conv_below(bl), .i_chan_enable(en),
	.o_conv_ready(rdy), .o_base_addr(base), .o_module_reset(mrst),
	.o_irq_level(lvl), .o_irq_enable(iren), .o_irq_status_id(sid),
	.o_buf_empty(empty));
vme_master vme_master_i (.i_clk_sys(clk), .i_ack(ack), .i_rdata(rdata),
	.o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wd));
task automatic test_done();
	if (error_cnt == 0 && checks > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
	checks++;
	if (g !== e)
	begin
		error_cnt++;
		$display("BAD %s exp %h got %h", n, e, g);
	end
endtask
task automatic rr(input logic [15:0] a, input logic [31:0] e, input string n);
	logic [31:0] q;
	logic k;
	vme_master_i.acc(1'b1, a, 16'h0000, q, k);
	cmp(n, e, q);
endtask
task automatic w(input logic [15:0] a, input logic [15:0] d);
	logic [31:0] q;
	logic k;
	vme_master_i.acc(1'b0, a, d, q, k);
endtask
function automatic word_t dw(int c, bit b, bit o);
	return {5'h0C, 6'h00, c[3:0], 3'h0, b, o, 12'h100 + c[11:0]};
endfunction
always @(posedge clk)
begin
	cyc++;
	if (cyc == 3000)
	begin
		error_cnt++;
		test_done();
	end
end
initial
begin
	logic [31:0] q;
	logic k;
	for (int c = 0; c < 16; c++)
		val[c*12+:12] = 12'h100 + c[11:0];
	repeat (20) @(negedge clk);
	nrst = 1'b1;
	@(negedge clk);
	rr(`OFS_FW_REV, 32'h0000_0A5C, "rev");
	rr(`OFS_SLOT, 32'h0000_000B, "slot");
	rr(`OFS_CHAIN, 32'h0000_00AA, "chain");
	rr(`OFS_IRQ_VEC, 32'h0000_0000, "vec");
	rr(16'h2000, 32'h0000_0000, "unmapped");
	rr(16'h0000, 32'h0600_0000, "empty");
	vme_master_i.acc(1'b0, `OFS_SLOT, 16'h0003, q, k);
	cmp("slot ack", 32'h0, {31'h0, k});
	slot = 5'h0C;
	rr(`OFS_SLOT, 32'h0000_000B, "slot kept");
	w(`OFS_SET1, 16'h0010);
	@(negedge clk);
	cmp("base", 32'h0000_00C4, {24'h0, base});
	@(negedge clk) be = 1'b1;
	@(negedge clk) be = 1'b0;
	rr(`OFS_SET1, 32'h0000_0018, "set");
	w(`OFS_CLR1, 16'h0008);
	rr(`OFS_SET1, 32'h0000_0010, "clr");
	@(negedge clk) be = 1'b1;
	@(negedge clk) be = 1'b0;
	w(`OFS_SET1, 16'h0080);
	@(negedge clk);
	cmp("hold", 32'h1, {31'h0, mrst});
	rr(`OFS_SET1, 32'h0000_0090, "sw rst");
	rr(`OFS_SLOT, 32'h0000_000C, "slot reload");
	w(`OFS_CLR1, 16'h0090);
	@(negedge clk);
	cmp("base sw", 32'h0000_0031, {24'h0, base});
	cmp("released", 32'h0, {31'h0, mrst});
	w(`OFS_IRQ_LVL, 16'h000D);
	w(`OFS_IRQ_VEC, 16'h00A5);
	@(negedge clk);
	cmp("lvl", 32'h0000_000D, {28'h0, iren, lvl});
	cmp("sid", 32'h0000_00A5, {24'h0, sid});
	@(negedge clk);
	{cv, en, ov, bl} = {1'b1, 16'h0109, 16'h0100, 16'h0008};
	for (int n = 0; n < 20 && rdy !== 1'b1; n++)
		@(negedge clk);
	@(negedge clk) cv = 1'b0;
	repeat (24) @(negedge clk);
	rr(16'h0000, 32'h625A_0300, "header");
	rr(16'h0000, dw(0, 0, 0), "ch0");
	rr(16'h0004, dw(8, 0, 1), "ch8");
	rr(16'h0008, dw(3, 1, 0), "ch3");
	rr(16'h0000, 32'h6400_1234, "trailer");
	rr(16'h0000, 32'h0600_0000, "drained");
	@(negedge clk);
	{zs, cv, en, bl} = {2'b11, 16'h0003, 16'h0003};
	for (int n = 0; n < 20 && rdy !== 1'b1; n++)
		@(negedge clk);
	@(negedge clk) cv = 1'b0;
	repeat (24) @(negedge clk);
	cmp("no event", 32'h1, {31'h0, empty});
	{kb, cv, ov} = {1'b1, 1'b1, 16'h0002};
	for (int n = 0; n < 20 && rdy !== 1'b1; n++)
		@(negedge clk);
	@(negedge clk) cv = 1'b0;
	repeat (24) @(negedge clk);
	rr(16'h0000, 32'h625A_0100, "kept hdr");
	rr(16'h0000, dw(0, 1, 0), "kept ch0");
	rr(16'h0000, 32'h6400_1234, "kept eob");
	@(negedge clk);
	cmp("empty again", 32'h1, {31'h0, empty});
	test_done();
end
endmodule
`default_nettype wire
